// >>> ds_pkg.sv
package ds_pkg;

	// ----------------------------------------
	// Clock and rate generation
	// ----------------------------------------
	localparam longint unsigned CLK_HZ        = 125_000_000;
	localparam int unsigned     TW_W          = 32;
	localparam int unsigned     BASE_PER_IN   = 64;
	localparam int unsigned     CNT_W         = 13;
	localparam int unsigned     RATIO_W       = 3;
	localparam int unsigned     LOG_MOD_OSR   = 6;
	localparam int unsigned     LOG_INTERP    = 3;
	localparam longint unsigned IN_MIN_MSPS   = 5_000_000;
	localparam longint unsigned IN_MAX_MSPS   = 204_800_000;
	localparam longint unsigned OUT_MIN_MSPS  = 1_250_000;
	localparam longint unsigned OUT_MAX_MSPS  = 51_200_000;
	// Both terms are divided down so the tuning-word products stay within 64 bits.
	localparam longint unsigned TW_PRESCALE   = 256;
	localparam longint unsigned TW_SCALE      = (64'd1 << TW_W) / TW_PRESCALE;
	localparam longint unsigned TW_DEN        = CLK_HZ * 1000 / TW_PRESCALE;
	localparam logic [39:0]     TW_IN_MIN     = 40'(IN_MIN_MSPS * BASE_PER_IN * TW_SCALE / TW_DEN);
	localparam logic [39:0]     TW_IN_MAX     = 40'(IN_MAX_MSPS * BASE_PER_IN * TW_SCALE / TW_DEN);
	localparam logic [39:0]     TW_OUT_MIN    = 40'(OUT_MIN_MSPS * BASE_PER_IN * TW_SCALE / TW_DEN);
	localparam logic [39:0]     TW_OUT_MAX    = 40'(OUT_MAX_MSPS * BASE_PER_IN * TW_SCALE / TW_DEN);
	localparam logic [TW_W-1:0] TW_RESET      = TW_IN_MIN[TW_W-1:0];

	// ----------------------------------------
	// Sample path
	// ----------------------------------------
	localparam int unsigned     SAMPLE_W      = 16;
	localparam int unsigned     INT_W         = 20;
	localparam logic [15:0]     ATT20_NUM     = 16'h1999;
	localparam logic [15:0]     ATT40_NUM     = 16'h028f;
	localparam int unsigned     ATT_SHIFT     = 16;
	localparam logic signed [INT_W-1:0] FB_POS = 20'sh0_8000;
	localparam logic [CNT_W-1:0] ZERO_RUN     = 13'h1000;

	typedef enum logic [1:0] {
		ATT_0DB,
		ATT_20DB,
		ATT_40DB
	} atten_t;

	typedef struct packed {
		logic signed [SAMPLE_W-1:0] ch1;
		logic signed [SAMPLE_W-1:0] ch0;
	} sample_pair_t;

endpackage

// >>> ds_modulator.sv
module ds_modulator (
	input  wire logic                               clk,
	input  wire logic                               rst,
	input  wire logic                               en,
	input  wire logic signed [ds_pkg::SAMPLE_W-1:0] x,
	output logic                                    bit_out
);

	logic signed [ds_pkg::INT_W-1:0] integ1;
	logic signed [ds_pkg::INT_W-1:0] integ2;
	logic signed [ds_pkg::INT_W-1:0] next_integ1;
	logic signed [ds_pkg::INT_W-1:0] next_integ2;
	logic                            next_bit_out;
	logic signed [ds_pkg::INT_W-1:0] fb;

	// ----------------------------------------
	// Second-order loop
	// ----------------------------------------
	// Noise-shaping digital loop.
	always_comb begin
		fb           = bit_out ? ds_pkg::FB_POS : -ds_pkg::FB_POS;
		next_integ1  = integ1;
		next_integ2  = integ2;
		next_bit_out = bit_out;
		if (en) begin
			next_integ1  = integ1 + ds_pkg::INT_W'(x) - fb;
			next_integ2  = integ2 + next_integ1 - fb;
			next_bit_out = ~next_integ2[ds_pkg::INT_W-1];
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			integ1  <= '0;
			integ2  <= '0;
			bit_out <= 1'b0;
		end else begin
			integ1  <= next_integ1;
			integ2  <= next_integ2;
			bit_out <= next_bit_out;
		end
	end

	chk_mod_hold: assert property (@(posedge clk) disable iff (rst) !en |=> $stable(bit_out))
		else $error("modulator bit changed without a tick");

endmodule // ds_modulator

// >>> ds_output_path.sv
module ds_output_path (
	input  wire logic                          clk,
	input  wire logic                          rst,
	input  wire logic [ds_pkg::TW_W-1:0]       rate_word,
	input  wire logic [ds_pkg::RATIO_W-1:0]    ratio_sel,
	input  wire logic [1:0]                    atten_sel,
	input  wire ds_pkg::sample_pair_t          sample_in,
	output logic                               sample_req,
	output logic                               in_sample_tick,
	output logic [1:0]                         dac_bit,
	output logic [1:0]                         dac_drive,
	output logic                               mute
);

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic low_ones(input logic [ds_pkg::CNT_W-1:0] cnt, input int unsigned n);
		logic [ds_pkg::CNT_W-1:0] mask;
		mask = ds_pkg::CNT_W'((1 << n) - 1);
		return (cnt & mask) == mask;
	endfunction

	function automatic logic signed [15:0] interp(input logic signed [15:0] a, input logic signed [15:0] b,
		input logic [2:0] ph);
		logic signed [20:0] d;
		d = (21'(b) - 21'(a)) * $signed({1'b0, ph});
		return 16'(21'(a) + (d >>> ds_pkg::LOG_INTERP));
	endfunction

	function automatic logic signed [15:0] attenuate(input logic signed [15:0] v, input ds_pkg::atten_t sel);
		logic signed [32:0] p;
		p = '0;
		case (sel)
			ds_pkg::ATT_0DB:  return v;
			ds_pkg::ATT_20DB: p = 33'(v) * $signed({1'b0, ds_pkg::ATT20_NUM});
			default:          p = 33'(v) * $signed({1'b0, ds_pkg::ATT40_NUM});
		endcase
		return 16'(p >>> ds_pkg::ATT_SHIFT);
	endfunction

	// ----------------------------------------
	// Rate generation
	// ----------------------------------------
	logic [ds_pkg::TW_W-1:0]    tw_eff;
	logic [ds_pkg::TW_W-1:0]    next_tw_eff;
	logic [ds_pkg::TW_W-1:0]    acc;
	logic [ds_pkg::TW_W-1:0]    next_acc;
	logic                       base_tick;
	logic                       next_base_tick;
	logic [ds_pkg::CNT_W-1:0]   cnt;
	logic [ds_pkg::CNT_W-1:0]   next_cnt;
	logic [39:0]                lo;
	logic [39:0]                hi;
	logic                       in_tick;
	logic                       out_tick;
	logic                       interp_tick;
	logic                       mod_tick;

	always_comb begin
		lo = ds_pkg::TW_OUT_MIN << ratio_sel;
		hi = ds_pkg::TW_OUT_MAX << ratio_sel;
		if (ds_pkg::TW_IN_MIN > lo) begin
			lo = ds_pkg::TW_IN_MIN;
		end
		if (ds_pkg::TW_IN_MAX < hi) begin
			hi = ds_pkg::TW_IN_MAX;
		end
		if ({8'h00, rate_word} < lo) begin
			next_tw_eff = lo[ds_pkg::TW_W-1:0];
		end else if ({8'h00, rate_word} > hi) begin
			next_tw_eff = hi[ds_pkg::TW_W-1:0];
		end else begin
			next_tw_eff = rate_word;
		end
		{next_base_tick, next_acc} = {1'b0, acc} + {1'b0, tw_eff};
		next_cnt = base_tick ? cnt + 1'b1 : cnt;
	end

	always_comb begin
		in_tick     = base_tick & low_ones(cnt, ds_pkg::LOG_MOD_OSR);
		mod_tick    = base_tick & low_ones(cnt, 32'(ratio_sel));
		interp_tick = base_tick & low_ones(cnt, ratio_sel + ds_pkg::LOG_MOD_OSR - ds_pkg::LOG_INTERP);
		out_tick    = base_tick & low_ones(cnt, ratio_sel + ds_pkg::LOG_MOD_OSR);
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			tw_eff    <= ds_pkg::TW_RESET;
			acc       <= '0;
			base_tick <= 1'b0;
			cnt       <= '0;
		end else begin
			tw_eff    <= next_tw_eff;
			acc       <= next_acc;
			base_tick <= next_base_tick;
			cnt       <= next_cnt;
		end
	end

	// ----------------------------------------
	// Sample intake, interpolation, mute
	// ----------------------------------------
	ds_pkg::sample_pair_t       cur;
	ds_pkg::sample_pair_t       prev;
	ds_pkg::sample_pair_t       next_cur;
	ds_pkg::sample_pair_t       next_prev;
	logic [2:0]                 phase;
	logic [2:0]                 next_phase;
	logic [ds_pkg::CNT_W-1:0]   zrun;
	logic [ds_pkg::CNT_W-1:0]   next_zrun;
	logic                       next_mute;
	logic                       pair_zero;
	logic signed [15:0]         mod_in [2];

	always_comb begin
		next_cur   = cur;
		next_prev  = prev;
		next_phase = phase;
		next_zrun  = zrun;
		pair_zero  = (sample_in.ch0 == '0) && (sample_in.ch1 == '0);
		if (sample_req) begin
			next_prev  = cur;
			next_cur   = sample_in;
			next_phase = '0;
			if (!pair_zero) begin
				next_zrun = '0;
			end else if (zrun != ds_pkg::ZERO_RUN) begin
				next_zrun = zrun + 1'b1;
			end
		end else if (interp_tick) begin
			next_phase = phase + 1'b1;
		end
		next_mute = (next_zrun == ds_pkg::ZERO_RUN);
		mod_in[0] = attenuate(interp(prev.ch0, cur.ch0, phase), ds_pkg::atten_t'(atten_sel));
		mod_in[1] = attenuate(interp(prev.ch1, cur.ch1, phase), ds_pkg::atten_t'(atten_sel));
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cur   <= '0;
			prev  <= '0;
			phase <= '0;
			zrun  <= '0;
			mute  <= 1'b0;
		end else begin
			cur   <= next_cur;
			prev  <= next_prev;
			phase <= next_phase;
			zrun  <= next_zrun;
			mute  <= next_mute;
		end
	end

	// ----------------------------------------
	// Modulators and outputs
	// ----------------------------------------
	logic [1:0] mod_bit;
	logic [1:0] next_dac_bit;
	logic [1:0] next_dac_drive;

	for (genvar c = 0; c < 2; c++) begin : g_ch
		ds_modulator u_mod (
			.clk     (clk),
			.rst     (rst),
			.en      (mod_tick),
			.x       (mod_in[c]),
			.bit_out (mod_bit[c])
		);
	end

	always_comb begin
		next_dac_bit   = mute ? 2'b00 : mod_bit;
		next_dac_drive = mute ? 2'b00 : 2'b11;
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sample_req     <= 1'b0;
			in_sample_tick <= 1'b0;
			dac_bit        <= '0;
			dac_drive      <= '0;
		end else begin
			sample_req     <= out_tick;
			in_sample_tick <= in_tick;
			dac_bit        <= next_dac_bit;
			dac_drive      <= next_dac_drive;
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	// Ticks stay aligned.
	chk_ticks_aligned: assert property (@(posedge clk) disable iff (rst) out_tick |-> in_tick)
		else $error("output tick without input tick");

	chk_ratio_one: assert property (@(posedge clk) disable iff (rst) (ratio_sel == 0) |-> (out_tick == in_tick))
		else $error("ratio one ticks differ");

	chk_rate_clamp: assert property (@(posedge clk) disable iff (rst)
		{8'h00, tw_eff} >= ds_pkg::TW_IN_MIN && {8'h00, tw_eff} <= ds_pkg::TW_IN_MAX)
		else $error("rate word outside limits");

	chk_tick_nest: assert property (@(posedge clk) disable iff (rst) out_tick |-> (interp_tick && mod_tick))
		else $error("sample tick not on modulator tick");

	chk_req_pulse: assert property (@(posedge clk) disable iff (rst) sample_req |=> !sample_req)
		else $error("sample request longer than one cycle");

	chk_zero_clear: assert property (@(posedge clk) disable iff (rst) sample_req && !pair_zero |=> zrun == 0 && !mute)
		else $error("nonzero sample did not clear zero run");

	chk_mute_entry: assert property (@(posedge clk) disable iff (rst)
		sample_req && pair_zero && zrun == ds_pkg::ZERO_RUN - 1 |=> mute)
		else $error("mute not entered after zero run");

	chk_mute_clamp: assert property (@(posedge clk) disable iff (rst) mute |=> dac_drive == 2'b00 && dac_bit == 2'b00)
		else $error("outputs not clamped in mute");

	chk_mute_exit: assert property (@(posedge clk) disable iff (rst)
		sample_req && !pair_zero |=> !mute ##1 dac_drive == 2'b11)
		else $error("mute not left on nonzero sample");

endmodule // ds_output_path

// >>> host_buffer_model.sv
module host_buffer_model (
	input  wire logic                 clk,
	input  wire logic                 rst,
	input  wire logic                 sample_req,
	input  wire ds_pkg::sample_pair_t fill,
	output ds_pkg::sample_pair_t      sample_in
);
	timeunit 1ns;
	timeprecision 1ps;

	// ----------------------------------------
	// Sample hand-over
	// ----------------------------------------
	// One pair per request.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sample_in <= '0;
		end else if (sample_req) begin
			sample_in <= fill;
		end
	end
endmodule // host_buffer_model

// >>> testbench.sv
module testbench;
	timeunit 1ns;
	timeprecision 1ps;

	// ----------------------------------------
	// Signals and instances
	// ----------------------------------------
	logic                 clk;
	logic                 rst;
	logic [31:0]          rate_word;
	logic [2:0]           ratio_sel;
	logic [1:0]           atten_sel;
	ds_pkg::sample_pair_t fill;
	ds_pkg::sample_pair_t sample_in;
	logic                 sample_req;
	logic                 in_sample_tick;
	logic [1:0]           dac_bit;
	logic [1:0]           dac_drive;
	logic                 mute;
	int                   mismatches;
	int                   checks_done;
	int                   cyc;
	int                   tk;
	int                   ones0;
	int                   ones1;
	int                   exp_hi[3] = '{875, 538, 504};
	int                   exp_lo[3] = '{125, 463, 496};

	ds_output_path u_dut (
		.clk            (clk),
		.rst            (rst),
		.rate_word      (rate_word),
		.ratio_sel      (ratio_sel),
		.atten_sel      (atten_sel),
		.sample_in      (sample_in),
		.sample_req     (sample_req),
		.in_sample_tick (in_sample_tick),
		.dac_bit        (dac_bit),
		.dac_drive      (dac_drive),
		.mute           (mute)
	);

	host_buffer_model u_host (
		.clk        (clk),
		.rst        (rst),
		.sample_req (sample_req),
		.fill       (fill),
		.sample_in  (sample_in)
	);

	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic test_done();
		$display("Counts: %0d checks, %0d mismatches", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	task automatic check_val(string name, logic [31:0] exp, logic [31:0] got);
		checks_done++;
		if (got !== exp) begin
			mismatches++;
			$display("ERROR %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic check_range(string name, int lo, int hi, int got);
		checks_done++;
		if (got < lo || got > hi) begin
			mismatches++;
			$display("ERROR %s expected %0d..%0d seen %0d", name, lo, hi, got);
		end
	endtask

	// Counts cycles, input ticks and ones of each stream over n output periods.
	task automatic run(int n);
		int k;
		k = 0;
		cyc = 0;
		tk = 0;
		ones0 = 0;
		ones1 = 0;
		while (k < n) begin
			@(negedge clk);
			cyc++;
			tk += (in_sample_tick === 1'b1);
			ones0 += (dac_bit[0] === 1'b1);
			ones1 += (dac_bit[1] === 1'b1);
			if (sample_req === 1'b1) begin
				k++;
			end
			if (cyc > 12000) begin
				mismatches++;
				test_done();
			end
		end
	endtask

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		int exp;
		int inr;
		mismatches = 0;
		checks_done = 0;
		rst = 1'b1;
		rate_word = 32'hffff_ffff;
		ratio_sel = 3'h0;
		atten_sel = 2'h0;
		fill = '0;
		repeat (16) @(posedge clk);
		@(negedge clk);
		rst = 1'b0;
		@(negedge clk);
		@(negedge clk);
		check_val("dac_drive", 32'h0000_0003, 32'(dac_drive));
		check_val("mute", 32'h0000_0000, 32'(mute));
		$display("Test reset done");
		for (int r = 0; r < 4; r++) begin
			@(negedge clk);
			ratio_sel = 3'(r);
			run(1);
			run(1);
			inr = ((51200 << r) < 204800) ? (51200 << r) : 204800;
			exp = 125000000 * (1 << r) / inr;
			check_range("out_period", exp - 3, exp + 3, cyc);
			check_val("in_ticks", 32'(1 << r), 32'(tk));
			$display("Test ratio %0d done", r);
		end
		check_val("mute_short_zero_run", 32'h0000_0000, 32'(mute));
		@(negedge clk);
		ratio_sel = 3'h0;
		fill.ch0 = 16'h6000;
		fill.ch1 = 16'ha000;
		for (int a = 0; a < 3; a++) begin
			@(negedge clk);
			atten_sel = 2'(a);
			run(3);
			run(4);
			check_range("ch0_density", exp_hi[a] - 15, exp_hi[a] + 15, ones0 * 1000 / cyc);
			check_range("ch1_density", exp_lo[a] - 15, exp_lo[a] + 15, ones1 * 1000 / cyc);
			check_val("dac_drive_on", 32'h0000_0003, 32'(dac_drive));
			check_val("mute_nonzero", 32'h0000_0000, 32'(mute));
			$display("Test attenuation %0d done", a);
		end
		test_done();
	end
endmodule // testbench
